// [hdl/jtbs_pin_sync.sv]
`timescale 1ns/1ps
module jtbs_pin_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Raw pins from outside the clock domain
  input wire logic [jtbs_pkg::SYNC_W-1:0] pins_raw,
  // Synchronised levels and test clock edges
  jtbs_link_if.syn lnk
);

  typedef struct packed {
    logic [jtbs_pkg::SYNC_W-1:0] s1;
    logic [jtbs_pkg::SYNC_W-1:0] s2;
    logic tck_prev;
  } jtbs_sync_t;

  jtbs_sync_t q;
  jtbs_sync_t d;

  // Two stages; only the second stage and later feed any logic
  always_comb begin
    d = q;
    d.s1 = pins_raw;
    d.s2 = q.s1;
    d.tck_prev = q.s2[jtbs_pkg::SY_TCK];
  end

  // Pin reset level is zero, so a pin high at reset shows up as an edge or release
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Edge finders read only the second stage and its one-clk delayed copy
  assign lnk.tck_rise = q.s2[jtbs_pkg::SY_TCK] & ~q.tck_prev;
  assign lnk.tck_fall = ~q.s2[jtbs_pkg::SY_TCK] & q.tck_prev;
  assign lnk.tck_lvl = q.s2[jtbs_pkg::SY_TCK];
  assign lnk.tms = q.s2[jtbs_pkg::SY_TMS];
  assign lnk.tdi = q.s2[jtbs_pkg::SY_TDI];
  assign lnk.ext_rst_n = q.s2[jtbs_pkg::SY_RSTN];
  assign lnk.pad_in = q.s2[jtbs_pkg::SYNC_W-1:jtbs_pkg::SY_PAD];

endmodule : jtbs_pin_sync

// [hdl/jtbs_tap_fsm.sv]
`timescale 1ns/1ps
module jtbs_tap_fsm (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Edges in, controller state out
  jtbs_link_if.fsm lnk
);

  typedef struct packed {
    jtbs_pkg::jtbs_tap_t state;
  } jtbs_fsm_t;

  jtbs_fsm_t q;
  jtbs_fsm_t d;

  // Sixteen-state table, advanced on a sampled rising test clock
  function automatic jtbs_pkg::jtbs_tap_t tap_next(input jtbs_pkg::jtbs_tap_t s,
                                                    input logic tms);
    jtbs_pkg::jtbs_tap_t n;
    n = s;
    case (s)
      jtbs_pkg::TAP_TLR: n = tms ? jtbs_pkg::TAP_TLR : jtbs_pkg::TAP_RTI;
      jtbs_pkg::TAP_RTI: n = tms ? jtbs_pkg::TAP_SEL_DR : jtbs_pkg::TAP_RTI;
      jtbs_pkg::TAP_SEL_DR: n = tms ? jtbs_pkg::TAP_SEL_IR : jtbs_pkg::TAP_CAP_DR;
      jtbs_pkg::TAP_CAP_DR: n = tms ? jtbs_pkg::TAP_EX1_DR : jtbs_pkg::TAP_SH_DR;
      jtbs_pkg::TAP_SH_DR: n = tms ? jtbs_pkg::TAP_EX1_DR : jtbs_pkg::TAP_SH_DR;
      jtbs_pkg::TAP_EX1_DR: n = tms ? jtbs_pkg::TAP_UPD_DR : jtbs_pkg::TAP_PA_DR;
      jtbs_pkg::TAP_PA_DR: n = tms ? jtbs_pkg::TAP_EX2_DR : jtbs_pkg::TAP_PA_DR;
      jtbs_pkg::TAP_EX2_DR: n = tms ? jtbs_pkg::TAP_UPD_DR : jtbs_pkg::TAP_SH_DR;
      jtbs_pkg::TAP_UPD_DR: n = tms ? jtbs_pkg::TAP_SEL_DR : jtbs_pkg::TAP_RTI;
      jtbs_pkg::TAP_SEL_IR: n = tms ? jtbs_pkg::TAP_TLR : jtbs_pkg::TAP_CAP_IR;
      jtbs_pkg::TAP_CAP_IR: n = tms ? jtbs_pkg::TAP_EX1_IR : jtbs_pkg::TAP_SH_IR;
      jtbs_pkg::TAP_SH_IR: n = tms ? jtbs_pkg::TAP_EX1_IR : jtbs_pkg::TAP_SH_IR;
      jtbs_pkg::TAP_EX1_IR: n = tms ? jtbs_pkg::TAP_UPD_IR : jtbs_pkg::TAP_PA_IR;
      jtbs_pkg::TAP_PA_IR: n = tms ? jtbs_pkg::TAP_EX2_IR : jtbs_pkg::TAP_PA_IR;
      jtbs_pkg::TAP_EX2_IR: n = tms ? jtbs_pkg::TAP_UPD_IR : jtbs_pkg::TAP_SH_IR;
      // Update-IR may go straight on to a data scan
      jtbs_pkg::TAP_UPD_IR: n = tms ? jtbs_pkg::TAP_SEL_DR : jtbs_pkg::TAP_RTI;
      default: n = jtbs_pkg::TAP_TLR;
    endcase
    return n;
  endfunction : tap_next

  // Held in reset state while the test pins are disabled
  always_comb begin
    d = q;
    if (!lnk.tap_en) begin
      d.state = jtbs_pkg::TAP_TLR;
    end else if (lnk.tck_rise) begin
      d.state = tap_next(q.state, lnk.tms);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '{state: jtbs_pkg::TAP_TLR};
    end else begin
      q <= d;
    end
  end

  assign lnk.state = q.state;

endmodule : jtbs_tap_fsm

// [hdl/jtbs_top.sv]
// Functional notes
// - Test pins enable on a test clock falling edge after external reset release.
// - Test clock low at reset release holds the processor core in reset.
// - Release bit from the access port clears the hold and lets the core run.
// - Five test clocks with mode select high always reach Test-Logic-Reset.
// - One clock with mode select low moves Test-Logic-Reset to Run-Test/Idle.
// - Test clock high at reset release keeps the test pins disabled.
// - Mode select 1,1,0,0 from idle reaches Shift-IR; four bits shift in.
// - Mode select 1,1,0 returns to idle; instruction latches in Update-IR.
// - Active instruction picks the data register between data in and out.
// - Mode select 1,0,0 from idle reaches Shift-DR; low mode select stays.
// - Shift-DR shifts out the values captured during Capture-DR.
// - Registers with a parallel latch update it in Update-DR.
// - A data scan may follow an instruction scan without passing idle.
// - Four mandatory instructions; identification is default after reset.
// - Bypass gives the shortest one-bit path through the device.
// - External reset puts all port outputs in high impedance at once; here three clk later, and not while boundary drive is on.
// - Boundary instruction drives latched values to pins once loaded.
// - Boundary scan is paced only by the test clock, not the chip clock; here the test clock is sampled on clk.
// - Bus port cannot write flash buffer while held; none at all protected.
// - Release write is ignored while the chip is protected.
// - Held flag reads one while the core is held in reset.
`timescale 1ns/1ps
module jtbs_top (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Test access pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo_o,
  output logic tdo_oe,
  // External reset pin
  input wire logic ext_rst_n,
  // Port pads
  input wire logic [jtbs_pkg::NPIN-1:0] pad_in,
  output logic [jtbs_pkg::NPIN-1:0] pad_out,
  output logic [jtbs_pkg::NPIN-1:0] pad_oe,
  // Functional drive from the chip
  input wire logic [jtbs_pkg::NPIN-1:0] core_out,
  input wire logic [jtbs_pkg::NPIN-1:0] core_oe,
  // Access port side
  // Release pulse comes in; hold, flag and gates go out
  input wire logic chip_protected,
  input wire logic cpu_release_bit,
  output logic cpu_hold_rst,
  output logic cpu_held_flag,
  output logic dbg_present,
  output logic bap_access_en,
  output logic bap_flash_buf_wr_en
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    // Entry control and core hold
    logic rstn_prev;
    logic dbg_en;
    logic dbg_lock;
    logic hold;
    // Instruction shift stage and active code
    logic [jtbs_pkg::IR_W-1:0] ir_sh;
    logic [jtbs_pkg::IR_W-1:0] ir;
    // Data shift paths and boundary latches
    logic [jtbs_pkg::ID_W-1:0] dr_sh;
    logic [jtbs_pkg::BSR_W-1:0] bsr_sh;
    logic [jtbs_pkg::BSR_W-1:0] bsr_upd;
    // Serial output
    logic tdo;
    logic tdo_oe;
    // Pad drive
    logic [jtbs_pkg::NPIN-1:0] pad_out;
    logic [jtbs_pkg::NPIN-1:0] pad_oe;
    // Bus access gates
    logic acc_en;
    logic fbuf_en;
  } jtbs_core_t;

  // Reset leaves the default instruction active, all else clear
  localparam jtbs_core_t RST_VAL = '{ir: jtbs_pkg::INS_IDCODE, default: '0};

  // Whole state in one register; d is its next value
  jtbs_core_t q;
  jtbs_core_t d;

  // Synchronised pins, test clock edges and controller state
  // Only this module drives the enable into the bundle
  jtbs_link_if lnk ();

  // Boundary capture vector and views of the update latch
  logic [jtbs_pkg::BSR_W-1:0] cap_vec;
  logic [jtbs_pkg::NPIN-1:0] upd_out;
  logic [jtbs_pkg::NPIN-1:0] upd_oe;
  // Decoded events and the selected data path
  // All are combinational views of registered state
  logic rst_release;
  logic extest_on;
  jtbs_pkg::jtbs_dr_t sel;

  // ****************************************
  // Pin synchroniser and controller
  // ****************************************

  // Test clock is sampled here, so its rate must stay well below clk
  // Each test clock phase needs more than one clk cycle;
  // a shorter one can fall between samples and be lost.
  // Mode select and data in share the delay, so they stay aligned
  jtbs_pin_sync u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pins_raw({pad_in, ext_rst_n, tdi, tms, tck}),
    .lnk(lnk.syn)
  );

  // Controller moves on the same sampled edges as the datapath
  jtbs_tap_fsm u_fsm (
    .clk(clk),
    .sys_rst(sys_rst),
    .lnk(lnk.fsm)
  );

  // Controller only runs once the test pins are enabled
  // Disabled, it sits in Test-Logic-Reset, so a session
  // always starts from a known state
  assign lnk.tap_en = q.dbg_en;

  // ****************************************
  // Decoding helpers
  // ****************************************

  // Register path chosen by the active instruction; unknown codes bypass
  // A chain of devices then still sees a one-bit path here
  // Shared by capture, shift, update and the output mux
  function automatic jtbs_pkg::jtbs_dr_t dr_select(input logic [jtbs_pkg::IR_W-1:0] ins);
    jtbs_pkg::jtbs_dr_t r;
    r = jtbs_pkg::DR_BYP;
    if (ins == jtbs_pkg::INS_IDCODE) begin
      r = jtbs_pkg::DR_ID;
    end else if (ins == jtbs_pkg::INS_EXTEST || ins == jtbs_pkg::INS_SAMPLE) begin
      r = jtbs_pkg::DR_BSR;
    end
    return r;
  endfunction : dr_select

  // Serial bit that the selected path presents at its output end
  // Identification and bypass share one shift register
  // Bypass uses only its bit 0, the shortest path there is
  function automatic logic dr_lsb(input jtbs_pkg::jtbs_dr_t s, input jtbs_core_t c);
    logic b;
    b = c.dr_sh[0];
    if (s == jtbs_pkg::DR_BSR) begin
      b = c.bsr_sh[0];
    end
    return b;
  endfunction : dr_lsb

  // Path select, reset release event and boundary pad drive
  assign sel = dr_select(q.ir);
  assign rst_release = lnk.ext_rst_n & ~q.rstn_prev;
  assign extest_on = q.dbg_en && (q.ir == jtbs_pkg::INS_EXTEST);

  // ****************************************
  // Boundary cells per pin
  // ****************************************

  // Capture takes the chip's own drive and the pad level
  // Each pin owns three cells: value, enable, input level
  // The input cell reads the synchronised pad, two clk old;
  // at test clock rates that is well inside one phase
  generate
    for (genvar i = 0; i < jtbs_pkg::NPIN; i++) begin : g_cell
      assign cap_vec[i*jtbs_pkg::CELLS+jtbs_pkg::CELL_OUT] = core_out[i];
      assign cap_vec[i*jtbs_pkg::CELLS+jtbs_pkg::CELL_OE] = core_oe[i];
      assign cap_vec[i*jtbs_pkg::CELLS+jtbs_pkg::CELL_IN] = lnk.pad_in[i];
      assign upd_out[i] = q.bsr_upd[i*jtbs_pkg::CELLS+jtbs_pkg::CELL_OUT];
      assign upd_oe[i] = q.bsr_upd[i*jtbs_pkg::CELLS+jtbs_pkg::CELL_OE];
    end
  endgenerate

  // ****************************************
  // Next state
  // ****************************************
  // One process computes every next value from the state
  // Later assignments in it take priority over earlier ones
  always_comb begin
    d = q;
    d.rstn_prev = lnk.ext_rst_n;

    // Entry control around the external reset release
    // High test clock at release locks the pins until the
    // next release; a low one arms them for the first fall.
    // Pins already enabled stay so when the reset pin drops,
    // so a debugger can keep control across a board reset
    if (rst_release) begin
      if (lnk.tck_lvl) begin
        d.dbg_lock = 1'b1;
        d.dbg_en = 1'b0;
      end else begin
        d.dbg_lock = 1'b0;
      end
    end else if (lnk.tck_fall && lnk.ext_rst_n && !q.dbg_lock) begin
      d.dbg_en = 1'b1;
    end

    // Set on release wins over a release write in the same cycle
    // Release write is ignored while protected; core stays held
    if (cpu_release_bit && !chip_protected) begin
      d.hold = 1'b0;
    end
    if (rst_release && !lnk.tck_lvl) begin
      d.hold = 1'b1;
    end

    // Rising test clock: capture, shift
    // The state seen is the one before this edge moves it,
    // so capture happens on the edge leaving a capture state
    // and each edge spent in a shift state moves one bit
    if (lnk.tck_rise && q.dbg_en) begin
      case (lnk.state)
        // Instruction path
        jtbs_pkg::TAP_CAP_IR: begin
          d.ir_sh = jtbs_pkg::IR_CAPTURE;
        end
        jtbs_pkg::TAP_SH_IR: begin
          d.ir_sh = {lnk.tdi, q.ir_sh[jtbs_pkg::IR_W-1:1]};
        end
        // Data paths; bypass captures zero
        jtbs_pkg::TAP_CAP_DR: begin
          if (sel == jtbs_pkg::DR_ID) begin
            d.dr_sh = jtbs_pkg::IDCODE_VAL;
          end else if (sel == jtbs_pkg::DR_BSR) begin
            d.bsr_sh = cap_vec;
          end else begin
            d.dr_sh = '0;
          end
        end
        jtbs_pkg::TAP_SH_DR: begin
          if (sel == jtbs_pkg::DR_ID) begin
            d.dr_sh = {lnk.tdi, q.dr_sh[jtbs_pkg::ID_W-1:1]};
          end else if (sel == jtbs_pkg::DR_BSR) begin
            d.bsr_sh = {lnk.tdi, q.bsr_sh[jtbs_pkg::BSR_W-1:1]};
          end else begin
            d.dr_sh[0] = lnk.tdi;
          end
        end
        // Other states move no bits
        default: begin
        end
      endcase
    end

    // Falling test clock: update latches and drive the serial output
    // Latches change on the fall, away from any shifting edge.
    // Output changes half a period before the far side
    // samples it on the next rising edge
    if (lnk.tck_fall && q.dbg_en) begin
      if (lnk.state == jtbs_pkg::TAP_UPD_IR) begin
        d.ir = q.ir_sh;
      end
      if (lnk.state == jtbs_pkg::TAP_UPD_DR && sel == jtbs_pkg::DR_BSR) begin
        d.bsr_upd = q.bsr_sh;
      end
      if (lnk.state == jtbs_pkg::TAP_SH_IR) begin
        d.tdo = q.ir_sh[0];
        d.tdo_oe = 1'b1;
      end else if (lnk.state == jtbs_pkg::TAP_SH_DR) begin
        d.tdo = dr_lsb(sel, q);
        d.tdo_oe = 1'b1;
      end else begin
        d.tdo_oe = 1'b0;
      end
    end

    // Reset state of the controller restores the default instruction
    // Output enable drops one clk after the pins are disabled,
    // so a locked port never drives its data out pin
    if (lnk.state == jtbs_pkg::TAP_TLR) begin
      d.ir = jtbs_pkg::INS_IDCODE;
    end
    if (!q.dbg_en) begin
      d.tdo_oe = 1'b0;
    end

    // Pad drive: boundary values, else functional, floated in reset
    // Boundary drive beats the float so a board test can run
    // with the chip in reset; the float follows the pin three
    // clk later, as the pin passes the synchroniser first
    if (extest_on) begin
      d.pad_out = upd_out;
      d.pad_oe = upd_oe;
    end else if (!lnk.ext_rst_n) begin
      d.pad_out = core_out;
      d.pad_oe = '0;
    end else begin
      d.pad_out = core_out;
      d.pad_oe = core_oe;
    end

    // Flash buffer gate follows the next hold value so it never lags it
    // Access gate lags protection by one clk cycle;
    // protection is a slow level, so that is harmless
    d.acc_en = !chip_protected;
    d.fbuf_en = !chip_protected && !d.hold;
  end

  // ****************************************
  // Registers
  // ****************************************
  // Single register stage for the whole state
  // Synchronous reset, so no reset branch reads a signal
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= RST_VAL;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  // Every output comes straight from the state register
  // Flag and hold share one bit, so they cannot disagree
  assign tdo_o = q.tdo;
  assign tdo_oe = q.tdo_oe;
  assign pad_out = q.pad_out;
  assign pad_oe = q.pad_oe;
  assign cpu_hold_rst = q.hold;
  assign cpu_held_flag = q.hold;
  assign dbg_present = q.dbg_en;
  assign bap_access_en = q.acc_en;
  assign bap_flash_buf_wr_en = q.fbuf_en;

endmodule : jtbs_top

// [pkg/jtbs_link_if.sv]
`timescale 1ns/1ps
interface jtbs_link_if;
  logic tck_rise;
  logic tck_fall;
  logic tck_lvl;
  logic tms;
  logic tdi;
  logic ext_rst_n;
  logic [jtbs_pkg::NPIN-1:0] pad_in;
  logic tap_en;
  jtbs_pkg::jtbs_tap_t state;

  modport syn (output tck_rise, tck_fall, tck_lvl, tms, tdi, ext_rst_n, pad_in);
  modport fsm (input tck_rise, tms, tap_en, output state);
  modport core (input tck_rise, tck_fall, tck_lvl, tms, tdi, ext_rst_n, pad_in, state,
    output tap_en);
endinterface : jtbs_link_if

// [pkg/jtbs_pkg.sv]
package jtbs_pkg;

  // ****************************************
  // Widths and sizes
  // ****************************************
  localparam int IR_W = 4;
  localparam int ID_W = 32;
  localparam int NPIN = 8;
  localparam int CELLS = 3;
  localparam int BSR_W = NPIN * CELLS;

  // Cell order inside one pin's slice of the ring
  localparam int CELL_OUT = 0;
  localparam int CELL_OE = 1;
  localparam int CELL_IN = 2;

  // Bit positions of the synchronised pin bundle
  localparam int SY_TCK = 0;
  localparam int SY_TMS = 1;
  localparam int SY_TDI = 2;
  localparam int SY_RSTN = 3;
  localparam int SY_PAD = 4;
  localparam int SYNC_W = SY_PAD + NPIN;

  // ****************************************
  // Instruction codes and capture values
  // ****************************************
  localparam logic [IR_W-1:0] INS_IDCODE = 4'h1;
  localparam logic [IR_W-1:0] INS_EXTEST = 4'h2;
  localparam logic [IR_W-1:0] INS_SAMPLE = 4'h3;
  localparam logic [IR_W-1:0] INS_BYPASS = 4'hf;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  // Identification value is arbitrary; bit 0 must stay one
  localparam logic [ID_W-1:0] IDCODE_VAL = 32'h1a5c_e0b3;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [15:0] {
    TAP_TLR = 16'h0001, TAP_RTI = 16'h0002, TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008, TAP_SH_DR = 16'h0010, TAP_EX1_DR = 16'h0020,
    TAP_PA_DR = 16'h0040, TAP_EX2_DR = 16'h0080, TAP_UPD_DR = 16'h0100,
    TAP_SEL_IR = 16'h0200, TAP_CAP_IR = 16'h0400, TAP_SH_IR = 16'h0800,
    TAP_EX1_IR = 16'h1000, TAP_PA_IR = 16'h2000, TAP_EX2_IR = 16'h4000,
    TAP_UPD_IR = 16'h8000
  } jtbs_tap_t;

  typedef enum logic [2:0] {
    DR_ID = 3'h1,
    DR_BYP = 3'h2,
    DR_BSR = 3'h4
  } jtbs_dr_t;

endpackage : jtbs_pkg

// [verification/jtbs_dbg_model.sv]
`timescale 1ns/1ps
module jtbs_dbg_model (
  // Test access pins
  output logic tck,
  output logic tms,
  output logic tdi,
  // Answer from the device
  input wire logic tdo_o
);
  // ****************************************
  // External debugger
  // ****************************************
  // Idle levels; tck starts high so the first release locks the pins
  initial begin
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One period; tdo read just before the rise, clock stands low afterwards
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #80;
    q = tdo_o;
    tck = 1'b1;
    #80;
    tck = 1'b0;
  endtask : step

  // Navigation period; tdi toggles since nothing samples it
  task automatic nav(input logic m);
    logic q;
    step(m, ~tdi, q);
  endtask : nav

  // Bare rise and fall of the test clock
  task automatic pulse();
    tck = 1'b1;
    #80;
    tck = 1'b0;
    #80;
  endtask : pulse

  // Five periods high, then one low into idle
  task automatic tap_reset();
    repeat (5) nav(1'b1);
    nav(1'b0);
  endtask : tap_reset

  // IR or DR scan, LSB first; pre skips Select-DR, post stops in Select-DR
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      input logic pre, input logic post, output logic [31:0] dout);
    dout = '0;
    if (!pre) begin
      nav(1'b1);
    end
    if (ir) begin
      nav(1'b1);
    end
    nav(1'b0);
    nav(1'b0);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], dout[i]);
    end
    nav(1'b1);
    nav(post);
  endtask : scan
endmodule : jtbs_dbg_model

// [verification/jtbs_top_assertions.sv]
`timescale 1ns/1ps
module jtbs_top_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Test clock, reset pin and pads
  input wire logic tck,
  input wire logic ext_rst_n,
  input wire logic [jtbs_pkg::NPIN-1:0] pad_oe,
  // Access port side
  input wire logic chip_protected,
  input wire logic cpu_release_bit,
  input wire logic cpu_hold_rst,
  input wire logic cpu_held_flag,
  input wire logic dbg_present,
  input wire logic bap_access_en,
  input wire logic bap_flash_buf_wr_en
);
  // ****************************************
  // Hold, access and pad checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  flag_mirror_a: assert property (cpu_held_flag == cpu_hold_rst)
    else $error("held flag differs from core hold");
  hold_set_a: assert property ($rose(cpu_hold_rst) |-> !tck && ext_rst_n)
    else $error("core hold set without low test clock at release");
  prot_keep_a: assert property (chip_protected && cpu_hold_rst |=> cpu_hold_rst)
    else $error("core hold cleared while protected");
  // Reset pin must be settled, since a release event with tck low re-arms the hold
  hold_clear_a: assert property (cpu_release_bit && !chip_protected
    && ext_rst_n && $past(ext_rst_n, 5) |=> !cpu_hold_rst)
    else $error("release write did not clear core hold");
  bap_gate_a: assert property (!$past(sys_rst) |-> bap_access_en == !$past(chip_protected))
    else $error("bus port access does not follow protection");
  fbuf_gate_a: assert property (bap_flash_buf_wr_en |-> !cpu_hold_rst && bap_access_en)
    else $error("flash buffer writable while held or protected");
  dbg_rise_a: assert property ($rose(dbg_present) |-> !tck && $past(tck, 8) && ext_rst_n)
    else $error("test pins enabled without test clock fall");
  pad_float_a: assert property ((!ext_rst_n && !dbg_present) [*4] |-> pad_oe == '0)
    else $error("pads driven during external reset");

  // Main scenarios reached
  cover property ($fell(cpu_hold_rst));
  cover property ($rose(dbg_present));
  cover property (chip_protected && cpu_release_bit && cpu_hold_rst);
endmodule : jtbs_top_chk

bind jtbs_top jtbs_top_chk u_chk (
  .clk(clk), .sys_rst(sys_rst), .tck(tck), .ext_rst_n(ext_rst_n), .pad_oe(pad_oe),
  .chip_protected(chip_protected), .cpu_release_bit(cpu_release_bit),
  .cpu_hold_rst(cpu_hold_rst), .cpu_held_flag(cpu_held_flag), .dbg_present(dbg_present),
  .bap_access_en(bap_access_en), .bap_flash_buf_wr_en(bap_flash_buf_wr_en)
);

// [verification/testbench.sv]
`timescale 1ns/1ps
module testbench;
  // ****************************************
  // Signals and design
  // ****************************************
  typedef struct {
    logic [jtbs_pkg::IR_W-1:0] code;
    int n;
    logic [31:0] din;
    logic [31:0] msk;
    logic [31:0] exp;
    logic direct;
  } jtbs_row_t;

  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ext_rst_n = 1'b0;
  logic chip_protected = 1'b0;
  logic cpu_release_bit = 1'b0;
  logic [jtbs_pkg::NPIN-1:0] pad_in = 8'h5a;
  logic [jtbs_pkg::NPIN-1:0] core_out = 8'h3c;
  logic [jtbs_pkg::NPIN-1:0] core_oe = 8'hff;
  logic [jtbs_pkg::NPIN-1:0] pad_out, pad_oe;
  logic tck, tms, tdi, tdo_o, tdo_oe;
  logic cpu_hold_rst, cpu_held_flag, dbg_present, bap_access_en, bap_flash_buf_wr_en;
  int num_errors = 0;
  int total_checks = 0;

  // 200 MHz system clock
  always #2.5 clk = ~clk;

  jtbs_top uut (
    .clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o),
    .tdo_oe(tdo_oe), .ext_rst_n(ext_rst_n), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .core_out(core_out), .core_oe(core_oe),
    .chip_protected(chip_protected), .cpu_release_bit(cpu_release_bit),
    .cpu_hold_rst(cpu_hold_rst), .cpu_held_flag(cpu_held_flag), .dbg_present(dbg_present),
    .bap_access_en(bap_access_en), .bap_flash_buf_wr_en(bap_flash_buf_wr_en)
  );

  jtbs_dbg_model dbg (.tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Inputs always move 1 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask : tend

  task automatic pulse_release();
    cpu_release_bit = 1'b1;
    cyc(1);
    cpu_release_bit = 1'b0;
    cyc(2);
  endtask : pulse_release

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  // Guard against a hung scan
  initial begin
    #300000;
    num_errors++;
    end_sim();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] q;
    logic [31:0] cap;
    logic [31:0] msk;
    logic [23:0] ring;
    logic [jtbs_pkg::NPIN-1:0] po, poe;
    jtbs_row_t rows [5];
    ring = 24'hc3a596;
    cap = '0;
    msk = '0;
    for (int i = 0; i < jtbs_pkg::NPIN; i++) begin
      msk[3*i+2] = 1'b1;
      cap[3*i+2] = pad_in[i];
      po[i] = ring[3*i];
      poe[i] = ring[3*i+1];
    end
    rows[0] = '{jtbs_pkg::INS_IDCODE, 32, 32'h0, 32'hffffffff, jtbs_pkg::IDCODE_VAL, 1'b1};
    rows[1] = '{jtbs_pkg::INS_BYPASS, 4, 32'hb, 32'hf, 32'h6, 1'b0};
    rows[2] = '{4'h7, 4, 32'hb, 32'hf, 32'h6, 1'b1};
    rows[3] = '{jtbs_pkg::INS_SAMPLE, 24, 32'(ring), msk, cap, 1'b0};
    rows[4] = '{jtbs_pkg::INS_EXTEST, 24, 32'(ring), msk, cap, 1'b0};
    cyc(12);
    sys_rst = 1'b0;
    cyc(4);
    chk(32'({dbg_present, cpu_hold_rst, tdo_oe, pad_oe}), 32'h0);
    tend("reset");
    // Release with tck high locks the pins
    ext_rst_n = 1'b1;
    cyc(6);
    dbg.pulse();
    chk(32'({dbg_present, cpu_hold_rst}), 32'h0);
    tend("locked");
    // Release with tck low holds the core
    ext_rst_n = 1'b0;
    cyc(6);
    ext_rst_n = 1'b1;
    cyc(6);
    chk(32'({cpu_hold_rst, cpu_held_flag, bap_flash_buf_wr_en}), 32'h6);
    dbg.pulse();
    chk(32'(dbg_present), 32'h1);
    chip_protected = 1'b1;
    cyc(2);
    pulse_release();
    chk(32'({cpu_hold_rst, bap_access_en}), 32'h2);
    chip_protected = 1'b0;
    cyc(2);
    pulse_release();
    chk(32'({cpu_hold_rst, bap_flash_buf_wr_en}), 32'h1);
    tend("hold");
    dbg.tap_reset();
    dbg.scan(1'b0, 32, 32'h0, 1'b0, 1'b0, q);
    chk(q, jtbs_pkg::IDCODE_VAL);
    tend("default id");
    // One row per instruction; EXTEST drives the preloaded ring at once
    foreach (rows[r]) begin
      dbg.scan(1'b1, 4, 32'(rows[r].code), 1'b0, rows[r].direct, q);
      chk(q, 32'(jtbs_pkg::IR_CAPTURE));
      if (rows[r].code == jtbs_pkg::INS_EXTEST) begin
        chk(32'({pad_oe, pad_out}), 32'({poe, po}));
      end
      dbg.scan(1'b0, rows[r].n, rows[r].din, rows[r].direct, 1'b0, q);
      chk(q & rows[r].msk, rows[r].exp);
      tend("row");
    end
    // Five high periods from inside Shift-DR restore the default
    dbg.scan(1'b1, 4, 32'(jtbs_pkg::INS_BYPASS), 1'b0, 1'b0, q);
    dbg.nav(1'b1);
    repeat (3) dbg.nav(1'b0);
    cyc(5);
    chk(32'(tdo_oe), 32'h1);
    dbg.tap_reset();
    dbg.scan(1'b0, 32, 32'h0, 1'b0, 1'b0, q);
    chk(q, jtbs_pkg::IDCODE_VAL);
    tend("tap reset");
    // Functional pads, then float under external reset
    cyc(4);
    chk(32'({tdo_oe, pad_oe, pad_out}), 32'hff3c);
    ext_rst_n = 1'b0;
    cyc(5);
    chk(32'(pad_oe), 32'h0);
    tend("float");
    end_sim();
  end
endmodule : testbench
